// ### rqs_defines.vh
// Purpose: Constants for the receive-queue steering block
// Assumes: Included by rqs_top.v and by the property and bench modules
// Notes:   Byte addresses on a 32-bit APB, one word per register
`ifndef RQS_DEFINES_VH
`define RQS_DEFINES_VH
// Register byte addresses
`define RQS_A_CTRL      8'h00
`define RQS_A_FEAT      8'h04
`define RQS_A_CMD       8'h08
`define RQS_A_DATA      8'h0C
`define RQS_A_COMMIT    8'h10
`define RQS_A_STATUS    8'h14
`define RQS_A_TXLIM     8'h18
`define RQS_A_OFF_LO    8'h1C
`define RQS_A_OFF_HI    8'h20
// Control register bits
`define RQS_C_LEGACY    0
`define RQS_C_GUEST_BE  1
`define RQS_C_RSS_OFF   2
// Command classes and commands
`define RQS_CLS_MQ      8'h04
`define RQS_CLS_OFFL    8'h05
`define RQS_CMD_PAIRS   8'h00
`define RQS_CMD_SCALE   8'h01
`define RQS_CMD_OFFSET  8'h00
// Acknowledge codes
`define RQS_ACK_OK      1'b0
`define RQS_ACK_ERR     1'b1
// Hash kind bits
`define RQS_H_IPV4      0
`define RQS_H_TCPV4     1
`define RQS_H_UDPV4     2
`define RQS_H_IPV6      3
`define RQS_H_TCPV6     4
`define RQS_H_UDPV6     5
`define RQS_H_IPEX      6
`define RQS_H_TCPEX     7
`define RQS_H_UDPEX     8
// Offload bits that follow negotiated features
`define RQS_OFFL_MASK   64'h0000_0000_0000_0782
// Sizes
`define RQS_TAB_MAX     16
`define RQS_TAB_MAX_W   16'h0010
`define RQS_KEY_MAX     8'h28
`define RQS_MAX_PAIRS   16'h0008
`define RQS_IN_W        288
// Hash input lengths in bits
`define RQS_LEN_V4      9'h040
`define RQS_LEN_V4P     9'h060
`define RQS_LEN_V6      9'h100
`define RQS_LEN_V6P     9'h120
// Parser states, one-hot
`define RQS_S_HT        0
`define RQS_S_MSK       1
`define RQS_S_FAL       2
`define RQS_S_TAB       3
`define RQS_S_TX        4
`define RQS_S_KLN       5
`define RQS_S_KEY       6
`define RQS_S_PAIR      7
`define RQS_S_OFF       8
`define RQS_S_DONE      9
`define RQS_S_BAD       10
// Steering modes, one-hot
`define RQS_M_SINGLE    3'h1
`define RQS_M_PAIRS     3'h2
`define RQS_M_SCALE     3'h4
`endif

// ### rqs_top.v
// Purpose: Receive-queue steering: command parser, hash, queue select
// Assumes: Command bytes arrive by APB writes; packet fields from logic
//          on pclk, so no synchronisers on them
// Notes:   Apply step swaps staged config into live config in one edge
//
// Function
// - After reset, steer everything to first queue
// - After pair command, never exceed active pairs; scaling mode does not check table entries or fallback against pairs
// - Legacy: pairs and offloads in guest order
// - Scaling uses Toeplitz hash with driver key
// - Parse scaling payload fields in fixed order
// - Index equals hash AND mask; mask+1 entries
// - Fallback and entries are zero-based queue numbers
// - Transmit queue limit taken from configuration
// - IPv4 priority TCP, UDP, addresses, none
// - Plain IPv6 same priority with IPv6 kinds
// - Extended kinds use home and routing addresses
// - No extended kind: hash as plain IPv6
// - No hash uses fallback, else table lookup
// - Offload set: one enables, zero disables
// - Offload bits follow negotiated feature defaults
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`include "rqs_defines.vh"
module rqs_top (
   // Clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // APB slave
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [7:0]   paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output reg          pready,
   output reg          pslverr,
   // Packet description
   input  wire         pkt_valid,
   input  wire         pkt_is_ipv4,
   input  wire         pkt_is_ipv6,
   input  wire         pkt_has_ext,
   input  wire         pkt_has_tcp,
   input  wire         pkt_has_udp,
   input  wire [127:0] pkt_src_addr,
   input  wire [127:0] pkt_dst_addr,
   input  wire         pkt_home_valid,
   input  wire [127:0] pkt_home_addr,
   input  wire         pkt_rt2_valid,
   input  wire [127:0] pkt_rt2_addr,
   input  wire [15:0]  pkt_src_port,
   input  wire [15:0]  pkt_dst_port,
   // Steering result
   output reg          pkt_ready,
   output reg          rx_queue_valid,
   output reg  [15:0]  rx_queue,
   output reg  [15:0]  tx_queue_limit,
   output reg  [63:0]  offload_en
);

////////////////////////////////////////////////////////////////////////
// Registers and state
reg  [2:0]   ctrl;
reg  [7:0]   cmd_class;
reg  [7:0]   cmd_code;
reg  [10:0]  pstate;
reg  [2:0]   sub;
reg  [63:0]  acc;
reg  [4:0]   tab_idx;
reg  [7:0]   key_idx;
reg  [31:0]  st_ht;
reg  [3:0]   st_mask;
reg  [15:0]  st_fall;
reg  [15:0]  st_tab [0:`RQS_TAB_MAX-1];
reg  [15:0]  st_tx;
reg  [7:0]   st_klen;
reg  [319:0] st_key;
reg  [15:0]  st_pairs;
reg  [63:0]  st_off;
reg  [2:0]   mode;
reg  [15:0]  pairs;
reg  [31:0]  ht;
reg  [3:0]   tmask;
reg  [15:0]  fall;
reg  [15:0]  tab [0:`RQS_TAB_MAX-1];
reg  [319:0] key;
reg          ack;
reg          busy;
reg          have_hash;
reg  [8:0]   bits_left;
reg  [287:0] in_sh;
reg  [319:0] key_sh;
reg  [31:0]  hash;
reg  [15:0]  flow;
integer      i;

wire         wr_acc = psel & penable & pready & pwrite;
wire [7:0]   db     = pwdata[7:0];
wire         be_ok  = ctrl[`RQS_C_LEGACY] & ctrl[`RQS_C_GUEST_BE];

////////////////////////////////////////////////////////////////////////
// Byte assembly: scaling fields are always little-endian
reg          use_le;
reg  [63:0]  next_acc;
always @* begin
   use_le   = 1'b1;
   next_acc = (sub == 3'h0) ? 64'h0 : acc;
   if (pstate[`RQS_S_PAIR] | pstate[`RQS_S_OFF])
      use_le = ~be_ok;
   if (use_le)
      next_acc[{sub, 3'b000} +: 8] = db;
   else
      next_acc = {next_acc[55:0], db};
end

////////////////////////////////////////////////////////////////////////
// APB slave, command parser and atomic apply
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
      ctrl       <= 3'h0;
      cmd_class  <= 8'h00;
      cmd_code   <= 8'h00;
      pstate     <= 11'h000;
      sub        <= 3'h0;
      acc        <= 64'h0;
      tab_idx    <= 5'h00;
      key_idx    <= 8'h00;
      st_ht      <= 32'h0000_0000;
      st_mask    <= 4'h0;
      st_fall    <= 16'h0000;
      st_tx      <= 16'h0000;
      st_klen    <= 8'h00;
      st_key     <= 320'h0;
      st_pairs   <= 16'h0000;
      st_off     <= 64'h0;
      mode       <= `RQS_M_SINGLE;
      pairs      <= 16'h0001;
      ht         <= 32'h0000_0000;
      tmask      <= 4'h0;
      fall       <= 16'h0000;
      key        <= 320'h0;
      ack        <= `RQS_ACK_OK;
      tx_queue_limit <= 16'h0001;
      offload_en <= 64'h0;
      for (i = 0; i < `RQS_TAB_MAX; i = i + 1) begin
         st_tab[i] <= 16'h0000;
         tab[i]    <= 16'h0000;
      end
   end else begin
      // One wait-free access phase; ready falls right after it
      pready  <= psel & ~penable & ~pready;
      pslverr <= 1'b0;
      if (psel & ~penable & ~pready) begin
         prdata <= 32'h0000_0000;
         case (paddr)
            `RQS_A_CTRL:   prdata <= {29'h0, ctrl};
            `RQS_A_STATUS: prdata <= {pairs, 4'h0, pstate[`RQS_S_DONE],
                                      mode, 7'h00, ack};
            `RQS_A_TXLIM:  prdata <= {16'h0000, tx_queue_limit};
            `RQS_A_OFF_LO: prdata <= offload_en[31:0];
            `RQS_A_OFF_HI: prdata <= offload_en[63:32];
            `RQS_A_FEAT, `RQS_A_CMD, `RQS_A_DATA, `RQS_A_COMMIT: ;
            default:       pslverr <= 1'b1;
         endcase
      end
      if (wr_acc) begin
         case (paddr)
            `RQS_A_CTRL: ctrl <= pwdata[2:0];
            `RQS_A_FEAT: offload_en <= {32'h0, pwdata} & `RQS_OFFL_MASK;
            `RQS_A_CMD: begin
               cmd_class <= pwdata[7:0];
               cmd_code  <= pwdata[15:8];
               sub       <= 3'h0;
               tab_idx   <= 5'h00;
               key_idx   <= 8'h00;
               st_key    <= 320'h0;
               pstate    <= 11'h000;
               if (pwdata[7:0] == `RQS_CLS_MQ &&
                   pwdata[15:8] == `RQS_CMD_SCALE)
                  pstate[`RQS_S_HT] <= 1'b1;
               else if (pwdata[7:0] == `RQS_CLS_MQ &&
                        pwdata[15:8] == `RQS_CMD_PAIRS)
                  pstate[`RQS_S_PAIR] <= 1'b1;
               else if (pwdata[7:0] == `RQS_CLS_OFFL &&
                        pwdata[15:8] == `RQS_CMD_OFFSET)
                  pstate[`RQS_S_OFF] <= 1'b1;
               else
                  pstate[`RQS_S_BAD] <= 1'b1;
            end
            `RQS_A_DATA: begin
               acc <= next_acc;
               sub <= sub + 3'h1;
               case (1'b1)
                  pstate[`RQS_S_HT]: if (sub == 3'h3) begin
                     st_ht  <= next_acc[31:0];
                     sub    <= 3'h0;
                     pstate <= 11'h1 << `RQS_S_MSK;
                  end
                  pstate[`RQS_S_MSK]: if (sub == 3'h1) begin
                     sub <= 3'h0;
                     st_mask <= next_acc[3:0];
                     if (next_acc[15:0] >= `RQS_TAB_MAX_W)
                        pstate <= 11'h1 << `RQS_S_BAD;
                     else
                        pstate <= 11'h1 << `RQS_S_FAL;
                  end
                  pstate[`RQS_S_FAL]: if (sub == 3'h1) begin
                     st_fall <= next_acc[15:0];
                     sub     <= 3'h0;
                     pstate  <= 11'h1 << `RQS_S_TAB;
                  end
                  pstate[`RQS_S_TAB]: if (sub == 3'h1) begin
                     st_tab[tab_idx[3:0]] <= next_acc[15:0];
                     sub     <= 3'h0;
                     tab_idx <= tab_idx + 5'h01;
                     if (tab_idx[3:0] == st_mask)
                        pstate <= 11'h1 << `RQS_S_TX;
                  end
                  pstate[`RQS_S_TX]: if (sub == 3'h1) begin
                     st_tx  <= next_acc[15:0];
                     sub    <= 3'h0;
                     pstate <= 11'h1 << `RQS_S_KLN;
                  end
                  pstate[`RQS_S_KLN]: begin
                     st_klen <= db;
                     sub     <= 3'h0;
                     if (db > `RQS_KEY_MAX)
                        pstate <= 11'h1 << `RQS_S_BAD;
                     else if (db == 8'h00)
                        pstate <= 11'h1 << `RQS_S_DONE;
                     else
                        pstate <= 11'h1 << `RQS_S_KEY;
                  end
                  pstate[`RQS_S_KEY]: begin
                     // Key is held first byte at the top
                     st_key[319 - {key_idx, 3'b000} -: 8] <= db;
                     sub     <= 3'h0;
                     key_idx <= key_idx + 8'h01;
                     if (key_idx + 8'h01 == st_klen)
                        pstate <= 11'h1 << `RQS_S_DONE;
                  end
                  pstate[`RQS_S_PAIR]: if (sub == 3'h1) begin
                     st_pairs <= next_acc[15:0];
                     pstate   <= 11'h1 << `RQS_S_DONE;
                  end
                  pstate[`RQS_S_OFF]: if (sub == 3'h7) begin
                     st_off <= next_acc;
                     pstate <= 11'h1 << `RQS_S_DONE;
                  end
                  // Trailing bytes make the command malformed
                  default: pstate <= 11'h1 << `RQS_S_BAD;
               endcase
            end
            `RQS_A_COMMIT: begin
               ack    <= `RQS_ACK_ERR;
               pstate <= 11'h000;
               if (pstate[`RQS_S_DONE]) begin
                  if (cmd_class == `RQS_CLS_OFFL) begin
                     offload_en <= st_off;
                     ack <= `RQS_ACK_OK;
                  end else if (cmd_code == `RQS_CMD_PAIRS) begin
                     if (st_pairs != 16'h0000 &&
                         st_pairs <= `RQS_MAX_PAIRS) begin
                        pairs <= st_pairs;
                        mode  <= (st_pairs == 16'h0001) ?
                                 `RQS_M_SINGLE : `RQS_M_PAIRS;
                        ack   <= `RQS_ACK_OK;
                     end
                  end else if (ctrl[`RQS_C_RSS_OFF] &&
                     ((st_mask + 4'h1) & st_mask) == 4'h0) begin
                     ht    <= st_ht;
                     tmask <= st_mask;
                     fall  <= st_fall;
                     key   <= st_key;
                     tx_queue_limit <= st_tx;
                     mode  <= `RQS_M_SCALE;
                     ack   <= `RQS_ACK_OK;
                     for (i = 0; i < `RQS_TAB_MAX; i = i + 1)
                        tab[i] <= st_tab[i];
                  end
               end
            end
            default: ;
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////
// Hash input selection
reg  [287:0] sel_in;
reg  [8:0]   sel_len;
reg          sel_ok;
wire [127:0] ex_src = pkt_home_valid ? pkt_home_addr : pkt_src_addr;
wire [127:0] ex_dst = pkt_rt2_valid ? pkt_rt2_addr : pkt_dst_addr;
wire [31:0]  ports  = {pkt_src_port, pkt_dst_port};
always @* begin
   sel_in  = 288'h0;
   sel_len = 9'h000;
   sel_ok  = 1'b0;
   if (pkt_is_ipv4) begin
      sel_ok = 1'b1;
      if (ht[`RQS_H_TCPV4] & pkt_has_tcp ||
          ht[`RQS_H_UDPV4] & pkt_has_udp) begin
         sel_in  = {pkt_src_addr[31:0], pkt_dst_addr[31:0], ports, 192'h0};
         sel_len = `RQS_LEN_V4P;
      end else if (ht[`RQS_H_IPV4]) begin
         sel_in  = {pkt_src_addr[31:0], pkt_dst_addr[31:0], 224'h0};
         sel_len = `RQS_LEN_V4;
      end else
         sel_ok  = 1'b0;
   end else if (pkt_is_ipv6) begin
      sel_ok = 1'b1;
      if (pkt_has_ext && (ht[`RQS_H_TCPEX] & pkt_has_tcp ||
                          ht[`RQS_H_UDPEX] & pkt_has_udp)) begin
         sel_in  = {ex_src, ex_dst, ports};
         sel_len = `RQS_LEN_V6P;
      end else if (pkt_has_ext && ht[`RQS_H_IPEX]) begin
         sel_in  = {ex_src, ex_dst, 32'h0};
         sel_len = `RQS_LEN_V6;
      end else if (ht[`RQS_H_TCPV6] & pkt_has_tcp ||
                   ht[`RQS_H_UDPV6] & pkt_has_udp) begin
         sel_in  = {pkt_src_addr, pkt_dst_addr, ports};
         sel_len = `RQS_LEN_V6P;
      end else if (ht[`RQS_H_IPV6]) begin
         sel_in  = {pkt_src_addr, pkt_dst_addr, 32'h0};
         sel_len = `RQS_LEN_V6;
      end else
         sel_ok  = 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////
// Serial Toeplitz engine: one input bit per cycle trades speed for area
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      busy           <= 1'b0;
      have_hash      <= 1'b0;
      bits_left      <= 9'h000;
      in_sh          <= 288'h0;
      key_sh         <= 320'h0;
      hash           <= 32'h0000_0000;
      flow           <= 16'h0000;
      pkt_ready      <= 1'b0;
      rx_queue_valid <= 1'b0;
      rx_queue       <= 16'h0000;
   end else begin
      rx_queue_valid <= 1'b0;
      pkt_ready      <= ~busy & ~(pkt_valid & pkt_ready);
      if (!busy && pkt_valid && pkt_ready) begin
         flow <= pkt_src_port ^ pkt_dst_port;
         if (mode == `RQS_M_SCALE) begin
            busy      <= 1'b1;
            have_hash <= sel_ok;
            in_sh     <= sel_in;
            key_sh    <= key;
            hash      <= 32'h0000_0000;
            bits_left <= sel_ok ? sel_len : 9'h000;
         end else begin
            rx_queue_valid <= 1'b1;
            rx_queue       <= 16'h0000;
            if (mode == `RQS_M_PAIRS &&
                {13'h0000, pkt_src_port[2:0] ^ pkt_dst_port[2:0]} < pairs)
               rx_queue <= {13'h0000,
                            pkt_src_port[2:0] ^ pkt_dst_port[2:0]};
         end
      end else if (busy) begin
         if (bits_left != 9'h000) begin
            if (in_sh[287])
               hash <= hash ^ key_sh[319:288];
            in_sh     <= {in_sh[286:0], 1'b0};
            key_sh    <= {key_sh[318:0], 1'b0};
            bits_left <= bits_left - 9'h001;
         end else begin
            busy           <= 1'b0;
            rx_queue_valid <= 1'b1;
            if (have_hash)
               rx_queue <= tab[hash[3:0] & tmask];
            else
               rx_queue <= fall;
         end
      end
   end
end

endmodule // rqs_top

// ### rqs_props.sv
// Purpose: Port-level checks for receive-queue steering
// Assumes: One pclk domain, async active-low reset
// Notes:   Bound to rqs_top after the module
`timescale 1ns/1ps
`include "rqs_defines.vh"
module rqs_props (
   // Clock and reset
   input wire        pclk,
   input wire        presetn,
   // APB
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire        pslverr,
   // Packets
   input wire        pkt_valid,
   input wire        pkt_ready,
   input wire        rx_queue_valid,
   input wire [15:0] rx_queue,
   input wire [15:0] tx_queue_limit,
   input wire [63:0] offload_en
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire  acc_w = psel && penable && pready && pwrite;
   wire  cmt   = acc_w && paddr == `RQS_A_COMMIT;
   logic cfg_seen;
   // Conservative: any commit ends the single-queue phase
   always @(posedge pclk or negedge presetn)
      if (!presetn) cfg_seen <= 1'b0;
      else if (cmt) cfg_seen <= 1'b1;
   ////////////////////////////////////////////////////////////////////////
   sequence s_take; pkt_valid && pkt_ready; endsequence
   sequence s_setup; psel && !penable && paddr[1:0] == 2'h0; endsequence
   property p_single_q; !cfg_seen && rx_queue_valid |-> rx_queue == 16'h0;
   endproperty
   a_single_q: assert property (p_single_q)
      else $error("queue other than first before config");
   property p_single_lat; s_take ##0 !cfg_seen |=> rx_queue_valid; endproperty
   a_single_lat: assert property (p_single_lat)
      else $error("single mode result late");
   property p_busy; s_take |=> !pkt_ready; endproperty
   a_busy: assert property (p_busy)
      else $error("ready right after take");
   property p_bound; s_take |-> ##[1:300] rx_queue_valid; endproperty
   a_bound: assert property (p_bound)
      else $error("no result for packet");
   property p_feat; acc_w && paddr == `RQS_A_FEAT
      |=> offload_en == ({32'h0, $past(pwdata)} & `RQS_OFFL_MASK); endproperty
   a_feat: assert property (p_feat)
      else $error("feature offload defaults wrong");
   property p_offl_src; $changed(offload_en) |->
      $past(acc_w && (paddr == `RQS_A_FEAT || paddr == `RQS_A_COMMIT));
   endproperty
   a_offl_src: assert property (p_offl_src)
      else $error("offloads changed without command");
   property p_tx_src; $changed(tx_queue_limit) |-> $past(cmt); endproperty
   a_tx_src: assert property (p_tx_src)
      else $error("tx limit changed without commit");
   property p_ready; s_setup ##0 paddr <= `RQS_A_OFF_HI
      |=> pready && !pslverr; endproperty
   a_ready: assert property (p_ready)
      else $error("mapped access not answered cleanly");
   property p_unmap; s_setup ##0 paddr > `RQS_A_OFF_HI |=> pready && pslverr;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped access not refused");
endmodule // rqs_props

bind rqs_top rqs_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .pslverr, .pkt_valid, .pkt_ready,
   .rx_queue_valid, .rx_queue, .tx_queue_limit, .offload_en);

// ### rqs_drv.sv
// Purpose: Guest driver model issuing control traffic over APB
// Assumes: Called right after a rising pclk edge
// Notes:   An idle cycle follows each transfer, so no signal is set twice
`timescale 1ns/1ps
module rqs_drv (
   // Clock
   input  wire         pclk,
   // APB master side
   output logic        psel,
   output logic        penable,
   output logic        pwrite,
   output logic [7:0]  paddr,
   output logic [31:0] pwdata,
   input  wire  [31:0] prdata,
   input  wire         pready,
   input  wire         pslverr
);
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
   end
   // Bytes go one per transfer, unpadded, class word first
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         rss_queue_steering_tb.error_cnt++;
         rss_queue_steering_tb.summarize();
      end
      @(posedge pclk);
   endtask
endmodule // rqs_drv

// ### rss_queue_steering_tb.sv
// Purpose: Self-checking bench for receive-queue steering
// Assumes: 25 MHz pclk, APB driver model in rqs_drv
// Notes:   Expected queues come from a local hash model
`timescale 1ns/1ps
`include "rqs_defines.vh"
module rss_queue_steering_tb;
   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, q;
   logic         pkt_valid, pkt_is_ipv4, pkt_is_ipv6, pkt_has_ext;
   logic         pkt_has_tcp, pkt_has_udp, pkt_home_valid, pkt_rt2_valid;
   logic [127:0] pkt_src_addr, pkt_dst_addr, pkt_home_addr, pkt_rt2_addr;
   logic [15:0]  pkt_src_port, pkt_dst_port, rx_queue, tx_queue_limit;
   logic         pkt_ready, rx_queue_valid, e;
   logic [63:0]  offload_en;
   logic [319:0] key;
   logic [15:0]  tab [4];
   int           error_cnt, tests_run;
   rqs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .pkt_valid, .pkt_is_ipv4, .pkt_is_ipv6,
      .pkt_has_ext, .pkt_has_tcp, .pkt_has_udp, .pkt_src_addr, .pkt_dst_addr,
      .pkt_home_valid, .pkt_home_addr, .pkt_rt2_valid, .pkt_rt2_addr,
      .pkt_src_port, .pkt_dst_port, .pkt_ready, .rx_queue_valid, .rx_queue,
      .tx_queue_limit, .offload_en);
   rqs_drv u_drv (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr);
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [63:0] s, input logic [63:0] x);
      tests_run++;
      if (s !== x) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      u_drv.xfer(1'b1, a, d, q, e);
   endtask
   task automatic sendb(input logic [63:0] v, input int n, input logic be);
      for (int i = 0; i < n; i++)
         wr(`RQS_A_DATA, {24'h0, v[8 * (be ? n - 1 - i : i) +: 8]});
   endtask
   task automatic cmd(input logic [7:0] c, input logic [7:0] m);
      wr(`RQS_A_CMD, {16'h0, m, c});
   endtask
   task automatic commit(input logic ack);
      wr(`RQS_A_COMMIT, 32'h0);
      u_drv.xfer(1'b0, `RQS_A_STATUS, 32'h0, q, e);
      chk(q[0], ack);
   endtask
   // Only enabled queues, four entries, mask 3, supported kinds
   task automatic cfg(input logic [31:0] k);
      cmd(`RQS_CLS_MQ, `RQS_CMD_SCALE);
      sendb(k, 4, 1'b0);
      sendb(16'h3, 2, 1'b0);
      sendb(16'h2, 2, 1'b0);
      for (int i = 0; i < 4; i++)
         sendb(tab[i], 2, 1'b0);
      sendb(16'h3, 2, 1'b0);
      sendb(8'd40, 1, 1'b0);
      for (int i = 0; i < 40; i++)
         sendb(key[319 - 8 * i -: 8], 1, 1'b0);
      commit(1'b0);
   endtask
   function automatic logic [15:0] qx(input logic v6, input logic p,
         input logic [127:0] s, input logic [15:0] a);
      logic [287:0] x;
      logic [31:0]  h;
      int           n;
      x = v6 ? {s, pkt_dst_addr, a, pkt_dst_port}
             : {s[31:0], pkt_dst_addr[31:0], a, pkt_dst_port, 192'h0};
      n = v6 ? (p ? 288 : 256) : (p ? 96 : 64);
      h = 32'h0;
      for (int i = 0; i < n; i++)
         if (x[287 - i]) h ^= key[319 - i -: 32];
      return tab[h[1:0]];
   endfunction
   // Flags: ipv4, ipv6, ext, tcp, udp
   task automatic pk(input logic [4:0] f, input logic [15:0] sp,
         input logic [15:0] x);
      int n;
      {pkt_is_ipv4, pkt_is_ipv6, pkt_has_ext, pkt_has_tcp, pkt_has_udp} <= f;
      pkt_src_port <= sp;
      pkt_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pkt_ready !== 1'b1 && n < 10);
      pkt_valid <= 1'b0;
      do begin
         @(posedge pclk);
         n++;
      end while (rx_queue_valid !== 1'b1 && n < 400);
      if (n >= 400) begin
         error_cnt++;
         summarize();
      end
      chk(rx_queue, x);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      error_cnt = 0;
      tests_run = 0;
      presetn = 1'b0;
      {pkt_valid, pkt_is_ipv4, pkt_is_ipv6, pkt_has_ext} = '0;
      {pkt_has_tcp, pkt_has_udp, pkt_rt2_valid, pkt_src_port} = '0;
      pkt_home_valid = 1'b1;
      pkt_dst_port = 16'h0;
      pkt_src_addr = {4{32'hC0A8_0A01}};
      pkt_dst_addr = {4{32'h0A00_00FE}};
      pkt_home_addr = {4{32'h2001_0DB8}};
      pkt_rt2_addr = {4{32'h5EED_0007}};
      key = {10{32'h6D5A_56DA}};
      tab = '{16'h1, 16'h3, 16'h0, 16'h2};
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(tx_queue_limit, 64'h1);
      chk(offload_en, 64'h0);
      pk(5'b10010, 16'h5, 16'h0);
      pk(5'b01001, 16'h6, 16'h0);
      $display("test reset done");
      wr(`RQS_A_FEAT, 32'hFFFF_FFFF);
      chk(offload_en, 64'h782);
      cmd(`RQS_CLS_OFFL, `RQS_CMD_OFFSET);
      sendb(64'h182, 8, 1'b0);
      commit(1'b0);
      chk(offload_en, 64'h182);
      wr(`RQS_A_CTRL, 32'h3);
      cmd(`RQS_CLS_OFFL, `RQS_CMD_OFFSET);
      sendb(64'h600, 8, 1'b1);
      commit(1'b0);
      chk(offload_en, 64'h600);
      commit(1'b1);
      u_drv.xfer(1'b0, 8'h40, 32'h0, q, e);
      chk(e, 1'b1);
      $display("test offloads done");
      cmd(`RQS_CLS_MQ, `RQS_CMD_PAIRS);
      sendb(16'h4, 2, 1'b1);
      commit(1'b0);
      wr(`RQS_A_CTRL, 32'h0);
      for (int v = 0; v < 8; v++)
         pk(5'b10010, v[15:0], (v < 4) ? v[15:0] : 16'h0);
      for (int v = 0; v < 2; v++) begin
         cmd(`RQS_CLS_MQ, `RQS_CMD_PAIRS);
         sendb(v ? 16'h9 : 16'h0, 2, 1'b0);
         commit(1'b1);
      end
      pk(5'b10010, 16'h3, 16'h3);
      $display("test pairs done");
      wr(`RQS_A_CTRL, 32'h4);
      cfg(32'h1FF);
      chk(tx_queue_limit, 64'h3);
      pk(5'b10010, 16'h1234, qx(1'b0, 1'b1, pkt_src_addr, 16'h1234));
      pk(5'b10000, 16'h1234, qx(1'b0, 1'b0, pkt_src_addr, 16'h1234));
      pk(5'b01001, 16'h0077, qx(1'b1, 1'b1, pkt_src_addr, 16'h0077));
      pk(5'b01110, 16'h0099, qx(1'b1, 1'b1, pkt_home_addr, 16'h99));
      pk(5'b00000, 16'h1234, 16'h2);
      cfg(32'h8);
      pk(5'b01110, 16'h0099, qx(1'b1, 1'b0, pkt_src_addr, 16'h99));
      pk(5'b10010, 16'h1234, 16'h2);
      cmd(`RQS_CLS_MQ, `RQS_CMD_SCALE);
      sendb(32'h1, 4, 1'b0);
      commit(1'b1);
      chk(tx_queue_limit, 64'h3);
      $display("test scaling done");
      summarize();
   end
endmodule // rss_queue_steering_tb
